// ===== design/mipc_regs.vh
// register offsets, field positions, reset values and encodings of the phase sequencer
`ifndef MIPC_REGS_VH
`define MIPC_REGS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define MIPC_ADDR_CTRL 8'h00
`define MIPC_ADDR_STATUS 8'h04
`define MIPC_ADDR_LU_CTRL 8'h08
`define MIPC_ADDR_DEST_CTRL 8'h0C
`define MIPC_ADDR_COMMIT_COUNT 8'h10
`define MIPC_ADDR_EXTEND_COUNT 8'h14

// ----------------------------------------------------------------
// control register fields and reset value
// ----------------------------------------------------------------
`define MIPC_CTRL_RUN_BIT 0
`define MIPC_CTRL_RESET 32'h00000001

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define MIPC_STAT_PENDING_BIT 0
`define MIPC_STAT_EXTENDED_BIT 1
`define MIPC_STAT_LAST_TYPE1_BIT 2
`define MIPC_STAT_LAST_MET_BIT 3

// ----------------------------------------------------------------
// microinstruction word layout
// ----------------------------------------------------------------
`define MIPC_MW_TYPE1_BIT 15
`define MIPC_MW_LIT_DEST_HI 13
`define MIPC_MW_LIT_DEST_LO 12

// literal destinations of a constant-bearing instruction
`define MIPC_LIT_TO_SHIFT 2'h0
`define MIPC_LIT_TO_LITERAL 2'h1
`define MIPC_LIT_TO_BOTH 2'h2
`define MIPC_LIT_TO_ALT_COUNT 2'h3

// ----------------------------------------------------------------
// nanoword bit positions, bit n carries nanobit n
// ----------------------------------------------------------------
`define MIPC_N_COND_LO 1
`define MIPC_N_COND_HI 4
`define MIPC_N_SENSE 5
`define MIPC_N_LU_UNCOND 6
`define MIPC_N_EXT_UNCOND 7
`define MIPC_N_ADJ_LO 8
`define MIPC_N_ADJ_HI 10
`define MIPC_N_SUCC_T_LO 11
`define MIPC_N_SUCC_T_HI 13
`define MIPC_N_SUCC_F_LO 14
`define MIPC_N_SUCC_F_HI 16
`define MIPC_N_LU_LO 17
`define MIPC_N_LU_HI 33
`define MIPC_N_DEST_LO 34
`define MIPC_N_DEST_HI 50
`define MIPC_N_EXT_LO 51
`define MIPC_N_EXT_HI 54
`define MIPC_N_SIGN_SAVE 55

// successor code sent for a constant-bearing instruction
`define MIPC_SUCC_STEP 3'h0

`endif

// ===== design/mipc_phase_ctl.v
// phase sequencer: phase 1 / phase 3 overlap, control register, deferred destination writes
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "mipc_regs.vh"

module mipc_phase_ctl #(
  parameter MW_WIDTH = 16,
  parameter LIT_WIDTH = 12,
  parameter NW_WIDTH = 56
) (
  input wire MCLK,
  input wire SYS_RST,
  input wire CLK_EN,
  input wire [MW_WIDTH-1:0] MICRO_WORD,
  input wire [NW_WIDTH-1:0] NANO_WORD,
  input wire [15:0] COND_IN,
  output wire [8:0] NANO_ADDR,
  output reg [2:0] SUCCESSOR_SEL,
  output reg [2:0] COND_ADJUST,
  output reg COND_ADJUST_VALID,
  output reg [3:0] EXTERNAL_OPERATION,
  output reg EXTERNAL_OPERATION_VALID,
  output reg [LIT_WIDTH-1:0] LITERAL_VALUE,
  output reg LOAD_SHIFT_AMOUNT,
  output reg LOAD_LITERAL,
  output reg LOAD_ALT_COUNT,
  output reg [16:0] LU_CONTROL,
  output reg LU_ACTIVE,
  output reg [16:0] DEST_SELECT,
  output reg SIGN_SAVE,
  output wire DEST_COMMIT,
  output wire EXTENDED_EXECUTE_PHASE,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output wire HREADYOUT,
  output wire HRESP
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // nanobit sense: polarity bit set means test for true
  function cond_met;
    input [15:0] conds;
    input [3:0] sel;
    input sense;
    begin
      cond_met = sense ? conds[sel] : ~conds[sel];
    end
  endfunction

  // a request is taken when it is unconditional or its test holds
  function needed;
    input uncond;
    input met;
    begin
      needed = uncond | met;
    end
  endfunction

  // an external field only issues when it is required and non-zero
  function issue;
    input req;
    input [3:0] field;
    begin
      issue = req & (field != 4'h0);
    end
  endfunction

  // one load strobe per literal destination: bit 0 shift, bit 1 literal, bit 2 alt count
  function [2:0] lit_loads;
    input [1:0] dest;
    begin
      case (dest)
        `MIPC_LIT_TO_SHIFT: begin
          lit_loads = 3'h1;
        end
        `MIPC_LIT_TO_LITERAL: begin
          lit_loads = 3'h2;
        end
        `MIPC_LIT_TO_BOTH: begin
          lit_loads = 3'h3;
        end
        default: begin
          lit_loads = 3'h4;
        end
      endcase
    end
  endfunction

  // address of each event counter: index 0 commits, index 1 extended clocks
  function [7:0] count_addr;
    input integer idx;
    begin
      if (idx == 0) begin
        count_addr = `MIPC_ADDR_COMMIT_COUNT;
      end else begin
        count_addr = `MIPC_ADDR_EXTEND_COUNT;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg run;
  reg pending;
  reg extended;
  reg last_type1;
  reg last_met;
  wire [15:0] commit_count;
  wire [15:0] extend_count;
  wire [1:0] count_event;
  wire [31:0] count_value;
  wire lit_step;
  reg bus_wr;
  reg [7:0] bus_addr;

  wire is_type1;
  wire [1:0] lit_dest;
  wire [3:0] cond_sel;
  wire met;
  wire lu_req;
  wire ext_req;
  wire [2:0] adj_field;
  wire [3:0] ext_field;
  wire step;
  wire new_phase3;
  wire addr_phase;
  wire bus_write_now;

  // ----------------------------------------------------------------
  // phase 1 decode
  // ----------------------------------------------------------------
  assign is_type1 = MICRO_WORD[`MIPC_MW_TYPE1_BIT];
  assign lit_dest = MICRO_WORD[`MIPC_MW_LIT_DEST_HI:`MIPC_MW_LIT_DEST_LO];
  assign NANO_ADDR = MICRO_WORD[8:0];
  assign cond_sel = NANO_WORD[`MIPC_N_COND_HI:`MIPC_N_COND_LO];
  assign met = cond_met(COND_IN, cond_sel, NANO_WORD[`MIPC_N_SENSE]);
  assign lu_req = is_type1 & needed(NANO_WORD[`MIPC_N_LU_UNCOND], met);
  assign ext_req = is_type1 & needed(NANO_WORD[`MIPC_N_EXT_UNCOND], met);
  assign adj_field = NANO_WORD[`MIPC_N_ADJ_HI:`MIPC_N_ADJ_LO];
  assign ext_field = NANO_WORD[`MIPC_N_EXT_HI:`MIPC_N_EXT_LO];
  assign step = run & CLK_EN;
  assign new_phase3 = step & lu_req;
  assign lit_step = step & ~is_type1;

  // the edge that ends a pending phase 3 is the one where a new one is needed
  // combinational: destinations latch on that edge with the DEST_SELECT seen now
  assign DEST_COMMIT = new_phase3 & pending;
  // pending and no new phase 3 requested this clock: the write is withheld
  assign EXTENDED_EXECUTE_PHASE = pending & ~lu_req;

  // ----------------------------------------------------------------
  // control register: logic and destination controls
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      LU_CONTROL <= 17'h00000;
      DEST_SELECT <= 17'h00000;
      SIGN_SAVE <= 1'b0;
      LU_ACTIVE <= 1'b0;
      pending <= 1'b0;
      extended <= 1'b0;
    end else if (new_phase3) begin
      LU_CONTROL <= NANO_WORD[`MIPC_N_LU_HI:`MIPC_N_LU_LO];
      DEST_SELECT <= NANO_WORD[`MIPC_N_DEST_HI:`MIPC_N_DEST_LO];
      SIGN_SAVE <= NANO_WORD[`MIPC_N_SIGN_SAVE];
      LU_ACTIVE <= 1'b1;
      pending <= 1'b1;
      extended <= 1'b0;
    end else if (step & pending) begin
      // controls stay put so the datapath keeps re-running the same operation
      extended <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // successor, condition adjust and external operation
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      SUCCESSOR_SEL <= `MIPC_SUCC_STEP;
      COND_ADJUST <= 3'h0;
      COND_ADJUST_VALID <= 1'b0;
      EXTERNAL_OPERATION <= 4'h0;
      EXTERNAL_OPERATION_VALID <= 1'b0;
      last_type1 <= 1'b0;
      last_met <= 1'b0;
    end else if (CLK_EN) begin
      if (step) begin
        last_type1 <= is_type1;
        last_met <= met;
        if (is_type1) begin
          SUCCESSOR_SEL <= met ? NANO_WORD[`MIPC_N_SUCC_T_HI:`MIPC_N_SUCC_T_LO]
                               : NANO_WORD[`MIPC_N_SUCC_F_HI:`MIPC_N_SUCC_F_LO];
        end else begin
          SUCCESSOR_SEL <= `MIPC_SUCC_STEP;
        end
        // zero-valued selections issue nothing
        COND_ADJUST <= adj_field;
        COND_ADJUST_VALID <= issue(ext_req, {1'b0, adj_field});
        EXTERNAL_OPERATION <= ext_field;
        EXTERNAL_OPERATION_VALID <= issue(ext_req, ext_field);
      end else begin
        COND_ADJUST_VALID <= 1'b0;
        EXTERNAL_OPERATION_VALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // literal loads of constant-bearing words
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      LITERAL_VALUE <= {LIT_WIDTH{1'b0}};
      LOAD_SHIFT_AMOUNT <= 1'b0;
      LOAD_LITERAL <= 1'b0;
      LOAD_ALT_COUNT <= 1'b0;
    end else if (CLK_EN) begin
      if (lit_step) begin
        LITERAL_VALUE <= MICRO_WORD[LIT_WIDTH-1:0];
        {LOAD_ALT_COUNT, LOAD_LITERAL, LOAD_SHIFT_AMOUNT} <= lit_loads(lit_dest);
      end else begin
        {LOAD_ALT_COUNT, LOAD_LITERAL, LOAD_SHIFT_AMOUNT} <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // event counters
  // ----------------------------------------------------------------
  // a software clear in the same cycle as an event still counts the event
  assign count_event = {step & EXTENDED_EXECUTE_PHASE, DEST_COMMIT};
  assign commit_count = count_value[15:0];
  assign extend_count = count_value[31:16];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_count
      reg [15:0] value;
      wire clear;
      assign clear = bus_write_now && (bus_addr == count_addr(gi));
      assign count_value[16*gi+15:16*gi] = value;
      always @(posedge MCLK) begin
        if (SYS_RST) begin
          value <= 16'h0000;
        end else if (CLK_EN) begin
          if (clear) begin
            value <= {15'h0000, count_event[gi]};
          end else if (count_event[gi]) begin
            value <= value + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign addr_phase = HSEL & HREADY & HTRANS[1];
  assign bus_write_now = bus_wr;

  // read data is sampled at the address phase, so a read straight after
  // a write to the same register returns the value before that write
  always @(posedge MCLK) begin
    if (SYS_RST) begin
      bus_wr <= 1'b0;
      bus_addr <= 8'h00;
      HRDATA <= 32'h00000000;
    end else if (CLK_EN) begin
      bus_wr <= addr_phase & HWRITE;
      if (addr_phase) begin
        bus_addr <= HADDR[7:0];
      end
      if (addr_phase & ~HWRITE) begin
        case (HADDR[7:0])
          `MIPC_ADDR_CTRL: begin
            HRDATA <= {31'h00000000, run};
          end
          `MIPC_ADDR_STATUS: begin
            HRDATA <= {28'h0000000, last_met, last_type1, extended, pending};
          end
          `MIPC_ADDR_LU_CTRL: begin
            HRDATA <= {14'h0000, LU_ACTIVE, LU_CONTROL};
          end
          `MIPC_ADDR_DEST_CTRL: begin
            HRDATA <= {14'h0000, SIGN_SAVE, DEST_SELECT};
          end
          `MIPC_ADDR_COMMIT_COUNT: begin
            HRDATA <= {16'h0000, commit_count};
          end
          `MIPC_ADDR_EXTEND_COUNT: begin
            HRDATA <= {16'h0000, extend_count};
          end
          default: begin
            HRDATA <= 32'h00000000;
          end
        endcase
      end
    end
  end

  always @(posedge MCLK) begin
    if (SYS_RST) begin
      // clearing run stops stepping but leaves a pending phase 3 in place
      run <= |(`MIPC_CTRL_RESET & 32'h00000001);
    end else if (CLK_EN && bus_wr && bus_addr == `MIPC_ADDR_CTRL) begin
      run <= HWDATA[`MIPC_CTRL_RUN_BIT];
    end
  end

endmodule // mipc_phase_ctl

// ===== verification/mipc_nano_model.sv
// nanomemory decoder model: nanoword per nano address
`timescale 1ns/1ps
module mipc_nano_model (
  input wire [8:0] nano_addr,
  output logic [55:0] nano_word
);
  // ----------------------------------------------------------------
  // decode table
  // ----------------------------------------------------------------
  // fields are derived from the address so every load is distinct
  always_comb begin
    nano_word = 56'h0;
    nano_word[4:1] = nano_addr[5:2];
    nano_word[5] = nano_addr[6];
    nano_word[6] = ~nano_addr[1];
    nano_word[7] = ~nano_addr[1];
    nano_word[10:8] = nano_addr[2:0];
    nano_word[13:11] = 3'h5;
    nano_word[16:14] = 3'h2;
    nano_word[33:17] = {8'hA5 ^ nano_addr[7:0], nano_addr};
    nano_word[50:34] = ~nano_word[33:17];
    nano_word[54:51] = nano_addr[3:0];
    nano_word[55] = nano_addr[0];
  end
endmodule // mipc_nano_model

// ===== verification/mipc_phase_ctl_properties.sv
// checker of phase sequencing at the sequencer ports
`timescale 1ns/1ps
module mipc_phase_ctl_properties #(
  parameter MW_WIDTH = 16,
  parameter LIT_WIDTH = 12,
  parameter NW_WIDTH = 56
) (
  input wire MCLK,
  input wire SYS_RST,
  input wire CLK_EN,
  input wire [MW_WIDTH-1:0] MICRO_WORD,
  input wire [NW_WIDTH-1:0] NANO_WORD,
  input wire [15:0] COND_IN,
  input wire [2:0] SUCCESSOR_SEL,
  input wire [2:0] COND_ADJUST,
  input wire COND_ADJUST_VALID,
  input wire [3:0] EXTERNAL_OPERATION,
  input wire EXTERNAL_OPERATION_VALID,
  input wire [LIT_WIDTH-1:0] LITERAL_VALUE,
  input wire LOAD_SHIFT_AMOUNT,
  input wire LOAD_LITERAL,
  input wire LOAD_ALT_COUNT,
  input wire [16:0] LU_CONTROL,
  input wire LU_ACTIVE,
  input wire [16:0] DEST_SELECT,
  input wire SIGN_SAVE,
  input wire DEST_COMMIT,
  input wire EXTENDED_EXECUTE_PHASE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  wire met = (COND_IN[NANO_WORD[4:1]] == NANO_WORD[5]);
  wire [2:0] lit_exp = (MICRO_WORD[13:12] == 2'h0) ? 3'h1 : (MICRO_WORD[13:12] == 2'h1) ? 3'h2 :
    (MICRO_WORD[13:12] == 2'h2) ? 3'h3 : 3'h4;
  sequence s_new_op; !SYS_RST && CLK_EN && MICRO_WORD[15] && (NANO_WORD[6] || met); endsequence
  sequence s_const; !SYS_RST && CLK_EN && !MICRO_WORD[15]; endsequence
  property p_lu_load; s_new_op |=> LU_CONTROL == $past(NANO_WORD[33:17]) &&
    DEST_SELECT == $past(NANO_WORD[50:34]) && SIGN_SAVE == $past(NANO_WORD[55]); endproperty
  a_lu_load: assert property (p_lu_load) else $error("controls not reloaded");
  property p_hold; s_const |=> $stable(LU_CONTROL) && $stable(DEST_SELECT); endproperty
  a_hold: assert property (p_hold) else $error("controls changed on constant word");
  property p_ext; s_const and LU_ACTIVE |-> EXTENDED_EXECUTE_PHASE && !DEST_COMMIT; endproperty
  a_ext: assert property (p_ext) else $error("no extension");
  property p_commit; s_new_op and LU_ACTIVE |-> DEST_COMMIT && !EXTENDED_EXECUTE_PHASE; endproperty
  a_commit: assert property (p_commit) else $error("pending write not committed");
  property p_cond_fail; !SYS_RST && CLK_EN && MICRO_WORD[15] && !NANO_WORD[6] && !met
    |-> !DEST_COMMIT ##1 $stable(LU_CONTROL) && $stable(DEST_SELECT); endproperty
  a_cond_fail: assert property (p_cond_fail) else $error("failed condition ran");
  property p_type2; s_const |=> SUCCESSOR_SEL == 3'h0 && LITERAL_VALUE == $past(MICRO_WORD[11:0]);
  endproperty
  a_type2: assert property (p_type2) else $error("constant word step or literal wrong");
  property p_lit_dest; s_const |=>
    {LOAD_ALT_COUNT, LOAD_LITERAL, LOAD_SHIFT_AMOUNT} == $past(lit_exp); endproperty
  a_lit_dest: assert property (p_lit_dest) else $error("literal destination wrong");
  property p_ext_op; !SYS_RST && CLK_EN && MICRO_WORD[15] && NANO_WORD[7] &&
    NANO_WORD[54:51] != 4'h0
    |=> EXTERNAL_OPERATION_VALID && EXTERNAL_OPERATION == $past(NANO_WORD[54:51]); endproperty
  a_ext_op: assert property (p_ext_op) else $error("external op not issued");
  property p_cond_adj; !SYS_RST && CLK_EN && MICRO_WORD[15] && (NANO_WORD[7] || met) &&
    NANO_WORD[10:8] != 3'h0 |=> COND_ADJUST_VALID && COND_ADJUST == $past(NANO_WORD[10:8]);
  endproperty
  a_cond_adj: assert property (p_cond_adj) else $error("condition adjust not issued");
  property p_no_ext; s_const |=> !COND_ADJUST_VALID && !EXTERNAL_OPERATION_VALID; endproperty
  a_no_ext: assert property (p_no_ext) else $error("constant word issued an operation");
  property p_succ; !SYS_RST && CLK_EN && MICRO_WORD[15] |=>
    SUCCESSOR_SEL == ($past(met) ? $past(NANO_WORD[13:11]) : $past(NANO_WORD[16:14])); endproperty
  a_succ: assert property (p_succ) else $error("successor wrong");
  property p_reset; $fell(SYS_RST) |-> !LU_ACTIVE && !DEST_COMMIT && LU_CONTROL == 17'h0; endproperty
  a_reset: assert property (p_reset) else $error("state left after reset");
  property p_freeze; !CLK_EN |=> $stable(LU_CONTROL) && $stable(SUCCESSOR_SEL); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule // mipc_phase_ctl_properties
bind mipc_phase_ctl mipc_phase_ctl_properties #(.MW_WIDTH(MW_WIDTH), .LIT_WIDTH(LIT_WIDTH),
  .NW_WIDTH(NW_WIDTH)) u_props (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .MICRO_WORD(MICRO_WORD), .NANO_WORD(NANO_WORD), .COND_IN(COND_IN),
  .SUCCESSOR_SEL(SUCCESSOR_SEL), .COND_ADJUST(COND_ADJUST),
  .COND_ADJUST_VALID(COND_ADJUST_VALID), .EXTERNAL_OPERATION(EXTERNAL_OPERATION),
  .EXTERNAL_OPERATION_VALID(EXTERNAL_OPERATION_VALID), .LITERAL_VALUE(LITERAL_VALUE),
  .LOAD_SHIFT_AMOUNT(LOAD_SHIFT_AMOUNT), .LOAD_LITERAL(LOAD_LITERAL),
  .LOAD_ALT_COUNT(LOAD_ALT_COUNT), .LU_CONTROL(LU_CONTROL), .LU_ACTIVE(LU_ACTIVE),
  .DEST_SELECT(DEST_SELECT), .SIGN_SAVE(SIGN_SAVE), .DEST_COMMIT(DEST_COMMIT),
  .EXTENDED_EXECUTE_PHASE(EXTENDED_EXECUTE_PHASE));

// ===== verification/microinstruction_phase_control_tb_top.sv
// bench: phase table, register bus, freeze and mid-run reset
`timescale 1ns/1ps
`include "mipc_regs.vh"
module microinstruction_phase_control_tb_top;
  typedef struct packed {logic [15:0] mw; logic [15:0] cnd; logic ld; logic ext; logic cmt;} mipc_row_t;
  logic MCLK = 0, SYS_RST = 1, CLK_EN = 1, HSEL = 0, HWRITE = 0;
  logic [15:0] MICRO_WORD = 16'h0000, COND_IN = 16'h0000;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rd;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [16:0] lu_exp;
  wire [55:0] NANO_WORD;
  wire [8:0] NANO_ADDR;
  wire [16:0] LU_CONTROL;
  wire [31:0] HRDATA;
  wire LU_ACTIVE, DEST_COMMIT, EXT, HREADYOUT, HRESP;
  int failures = 0, checked = 0, i;
  // ----------------------------------------------------------------
  // phase table: pattern of present and missing logic operations
  // ----------------------------------------------------------------
  mipc_row_t rows [9] = '{'{16'h8004, 16'h0, 1'b1, 1'b0, 1'b0}, '{16'h0123, 16'h0, 1'b0, 1'b1, 1'b0},
    '{16'h1456, 16'h0, 1'b0, 1'b1, 1'b0}, '{16'h800A, 16'h4, 1'b0, 1'b1, 1'b0},
    '{16'h800A, 16'h0, 1'b1, 1'b0, 1'b1}, '{16'h2789, 16'h0, 1'b0, 1'b1, 1'b0},
    '{16'h3ABC, 16'h0, 1'b0, 1'b1, 1'b0}, '{16'h8044, 16'h0, 1'b1, 1'b0, 1'b1},
    '{16'h8008, 16'h0, 1'b1, 1'b0, 1'b1}};
  mipc_nano_model u_nano (.nano_addr(NANO_ADDR), .nano_word(NANO_WORD));
  mipc_phase_ctl dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .MICRO_WORD(MICRO_WORD),
    .NANO_WORD(NANO_WORD), .COND_IN(COND_IN), .NANO_ADDR(NANO_ADDR), .SUCCESSOR_SEL(),
    .COND_ADJUST(), .COND_ADJUST_VALID(), .EXTERNAL_OPERATION(), .EXTERNAL_OPERATION_VALID(),
    .LITERAL_VALUE(), .LOAD_SHIFT_AMOUNT(), .LOAD_LITERAL(), .LOAD_ALT_COUNT(),
    .LU_CONTROL(LU_CONTROL), .LU_ACTIVE(LU_ACTIVE), .DEST_SELECT(), .SIGN_SAVE(),
    .DEST_COMMIT(DEST_COMMIT), .EXTENDED_EXECUTE_PHASE(EXT), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP));
  initial forever #5 MCLK = ~MCLK;
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // entered just after a rising edge; waits on hready, no fixed latency assumed
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1) @(posedge MCLK);
    r = HRDATA;
  endtask
  task complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    ahb(1'b0, `MIPC_ADDR_CTRL, 32'h0, rd);
    chk(rd, 32'h1, "ctrl reset");
    chk(HRESP, 1'b0, "okay response");
    ahb(1'b0, `MIPC_ADDR_LU_CTRL, 32'h0, rd);
    chk(rd, 32'h0, "lu reset");
    ahb(1'b0, 32'h40, 32'h0, rd);
    chk(rd, 32'h0, "unmapped");
    ahb(1'b1, `MIPC_ADDR_COMMIT_COUNT, 32'h0, rd);
    $display("test reset_bus done");
    lu_exp = 17'h0;
    for (i = 0; i < 9; i++) begin
      @(posedge MCLK);
      MICRO_WORD <= rows[i].mw;
      COND_IN <= rows[i].cnd;
      #2;
      chk(EXT, rows[i].ext, "extend");
      chk(DEST_COMMIT, rows[i].cmt, "commit");
      chk(LU_CONTROL, lu_exp, "lu ctrl");
      if (rows[i].ld) lu_exp = {8'hA5 ^ rows[i].mw[7:0], rows[i].mw[8:0]};
    end
    @(posedge MCLK);
    MICRO_WORD <= 16'h0123;
    #2 chk(LU_CONTROL, lu_exp, "last load");
    ahb(1'b0, `MIPC_ADDR_COMMIT_COUNT, 32'h0, rd);
    chk(rd, 32'h3, "commits");
    ahb(1'b0, `MIPC_ADDR_DEST_CTRL, 32'h0, rd);
    chk(rd, {15'h0000, ~lu_exp}, "dest ctrl");
    $display("test phase_table done");
    @(posedge MCLK);
    CLK_EN <= 1'b0;
    MICRO_WORD <= 16'h8044;
    @(posedge MCLK);
    #2 chk(LU_CONTROL, lu_exp, "frozen");
    @(posedge MCLK);
    CLK_EN <= 1'b1;
    @(posedge MCLK);
    #2 chk(LU_CONTROL, {8'hE1, 9'h044}, "resume");
    $display("test freeze done");
    @(posedge MCLK);
    SYS_RST <= 1'b1;
    MICRO_WORD <= 16'h0123;
    @(posedge MCLK);
    SYS_RST <= 1'b0;
    #2 chk(LU_ACTIVE, 1'b0, "active");
    chk(EXT, 1'b0, "no pending");
    chk(LU_CONTROL, 17'h0, "cleared");
    ahb(1'b0, `MIPC_ADDR_EXTEND_COUNT, 32'h0, rd);
    chk(rd, 32'h0, "extend count");
    $display("test mid_reset done");
    complete_run;
  end
endmodule // microinstruction_phase_control_tb_top
